// File: verilog/wdg_pkg.sv
// Functional notes
// R1 - Hardware option: always active, bit forced
// R2 - Hardware option: activation bit read unreliable
// R3 - Software option: inactive until bit written
// R4 - Once active, clearing writes are ignored
// R5 - Seven-bit counter decrements every 3072 cycles
// R6 - Timeout programmable in 64 steps
// R7 - Trigger bit zero while active: reset pulse
// R8 - Software refreshes register before expiry
// R9 - Refresh values FEh down to 02h
// R10 - Software keeps activation and trigger set
// R11 - Writing trigger zero while active resets
// R12 - Interrupt pin high by default for stop
// R13 - One register at 0D8h, reversed timing bits
// R14 - Register resets to FEh
// R15 - Active watchdog: stop becomes wait unless gated
////////////////////////////////////////////////////////////////////////////////
package wdg_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int DECR_CYCLES   = 3072;
   localparam int RST_PULSE_NS  = 500;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register map, byte addresses on an 8-bit address bus
   localparam int              ADDR_W     = 8;
   localparam logic [7:0]      ADDR_WATCHDOG_COUNT_CONTROL_REG  = 8'hd8;
   localparam logic [7:0]      ADDR_STAT  = 8'hdc;
   localparam logic [7:0]      WATCHDOG_COUNT_CONTROL_REG_RESET = 8'hfe;

   // Watchdog register fields
   localparam int C_BIT   = 0;
   localparam int SR_BIT  = 1;
   localparam int T_TOP   = 7;
   localparam int T_W     = 6;
   localparam int CNT_W   = 7;

   // Status register fields
   localparam int STAT_HW     = 0;
   localparam int STAT_EXT    = 1;
   localparam int STAT_ACTIVE = 2;
   localparam int STAT_STOP   = 3;
   localparam int STAT_FIRED  = 4;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Option straps as seen after synchronisation
   typedef struct packed {
      logic ext_stop_gate;
      logic hw_activation;
   } wdg_opt_s;

   // Counter: trigger bit on top of six timing bits
   typedef struct packed {
      logic           sr;
      logic [T_W-1:0] t;
   } wdg_cnt_s;

   typedef enum {ST_IDLE, ST_PULSE, ST_FIRED} wdg_fire_e;

endpackage : wdg_pkg

// File: verilog/wdg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_sync
   import wdg_pkg::*;
#(
   parameter int WIDTH = 1
)(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // Two-stage synchroniser; the first stage feeds only the second
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta     <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : wdg_sync
`default_nettype wire

// File: verilog/wdg_tick.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_tick
   import wdg_pkg::*;
#(
   parameter int PERIOD = DECR_CYCLES
)(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   input  wire logic clr,
   output logic      tick
);

   localparam int PW = $clog2(PERIOD);
   localparam logic [PW-1:0] LAST = PW'(PERIOD - 1);

   logic [PW-1:0] cnt;
   logic [PW-1:0] next_cnt;

   // Elaboration check: a period below two leaves no room for the wrap
   if (PERIOD < 2)
   begin : g_bad_period
      $error("wdg_tick: PERIOD must be at least 2");
   end

   // Prescaler; a reload restarts it so a fresh count gets a full step
   always_comb
   begin
      next_cnt = cnt;
      if (clr)
         next_cnt = '0;
      else if (run)
         next_cnt = (cnt == LAST) ? '0 : cnt + 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end

   assign tick = run && !clr && (cnt == LAST); // R5

endmodule : wdg_tick
`default_nettype wire

// File: verilog/wdg_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_top
   import wdg_pkg::*;
#(
   parameter int DECR_PERIOD = DECR_CYCLES,
   parameter int PULSE_CYC   = RST_PULSE_CYC
)(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Option straps and pins
   input  wire logic              activation_source_option,
   input  wire logic              external_stop_gate_option,
   input  wire logic              nmi_pin,
   // Core side
   input  wire logic              stop_req,
   output logic                   stop_mode,
   output logic                   wdg_reset_n
);

   // Elaboration check; the pulse helper counter below is only eight bits wide
   if (DECR_PERIOD < 2 || PULSE_CYC < 1 || PULSE_CYC > 256)
   begin : g_bad_timing
      $error("wdg_top: bad timing parameters");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and prescaler

   logic [2:0] pins_q;
   wdg_opt_s   opt;
   logic       nmi_q;
   logic       tick;
   logic       wr_watchdog_count_control_reg;
   logic       active;
   logic       sw_act;
   wdg_cnt_s   cnt;

   wdg_sync #(.WIDTH(3)) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({nmi_pin, external_stop_gate_option, activation_source_option}),
      .sync_out (pins_q)
   );

   assign opt.hw_activation = pins_q[0];
   assign opt.ext_stop_gate = pins_q[1];
   assign nmi_q             = pins_q[2];

   // Counter freezes only while the core really sits in stop
   wdg_tick #(.PERIOD(DECR_PERIOD)) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (!stop_mode),
      .clr     (wr_watchdog_count_control_reg),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write and read channels

   logic              aw_held, next_aw_held;
   logic              w_held, next_w_held;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [7:0]        w_data, next_w_data;
   logic              w_lane0, next_w_lane0;
   logic              next_bvalid;
   logic [1:0]        next_bresp;
   logic              next_rvalid;
   logic [1:0]        next_rresp;
   logic [31:0]       next_rdata;
   logic              do_write;
   logic [7:0]        watchdog_count_control_reg_view;
   logic [7:0]        stat_view;
   wdg_fire_e         fire_st;

   // Write fires once address and data are both held and no answer is pending
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_watchdog_count_control_reg  = do_write && (aw_addr[ADDR_W-1:2] == ADDR_WATCHDOG_COUNT_CONTROL_REG[7:2]) && w_lane0;

   always_comb
   begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_lane0 = w_lane0;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         // Status register is read-only; writes to it are accepted and dropped
         if (aw_addr[ADDR_W-1:2] == ADDR_WATCHDOG_COUNT_CONTROL_REG[7:2] || aw_addr[ADDR_W-1:2] == ADDR_STAT[7:2])
            next_bresp = RESP_OKAY;
         else
            next_bresp = RESP_SLVERR;
      end
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held  = 1'b1;
         next_w_data  = s_axi_wdata[7:0];
         next_w_lane0 = s_axi_wstrb[0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held       <= 1'b0;
         aw_addr       <= '0;
         w_held        <= 1'b0;
         w_data        <= '0;
         w_lane0       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else
      begin
         aw_held       <= next_aw_held;
         aw_addr       <= next_aw_addr;
         w_held        <= next_w_held;
         w_data        <= next_w_data;
         w_lane0       <= next_w_lane0;
         s_axi_awready <= !next_aw_held;
         s_axi_wready  <= !next_w_held;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
      end
   end

   // Read view: timing bits in reversed order, trigger, activation
   always_comb
   begin
      watchdog_count_control_reg_view = '0;
      for (int i = 0; i < T_W; i++)
         watchdog_count_control_reg_view[T_TOP-i] = cnt.t[i]; // R13
      watchdog_count_control_reg_view[SR_BIT] = cnt.sr;
      watchdog_count_control_reg_view[C_BIT]  = active; // R2
      stat_view              = '0;
      stat_view[STAT_HW]     = opt.hw_activation;
      stat_view[STAT_EXT]    = opt.ext_stop_gate;
      stat_view[STAT_ACTIVE] = active;
      stat_view[STAT_STOP]   = stop_mode;
      stat_view[STAT_FIRED]  = (fire_st != ST_IDLE);
   end

   always_comb
   begin
      next_rvalid = s_axi_rvalid;
      next_rresp  = s_axi_rresp;
      next_rdata  = s_axi_rdata;
      if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         next_rdata  = '0;
         if (s_axi_araddr[ADDR_W-1:2] == ADDR_WATCHDOG_COUNT_CONTROL_REG[7:2])
            next_rdata[7:0] = watchdog_count_control_reg_view;
         else if (s_axi_araddr[ADDR_W-1:2] == ADDR_STAT[7:2])
            next_rdata[7:0] = stat_view;
         else
            next_rresp = RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= '0;
         s_axi_arready <= 1'b0;
      end
      else
      begin
         s_axi_rvalid  <= next_rvalid;
         s_axi_rresp   <= next_rresp;
         s_axi_rdata   <= next_rdata;
         s_axi_arready <= !next_rvalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter, activation and stop handling

   wdg_cnt_s  next_cnt;
   logic      next_sw_act;
   logic      next_stop_mode;

   assign active = opt.hw_activation || sw_act; // R1 R3

   always_comb
   begin
      next_cnt    = cnt;
      next_sw_act = sw_act;
      if (wr_watchdog_count_control_reg)
      begin
         // A refresh reloads all seven bits; timing bits arrive reversed
         for (int i = 0; i < T_W; i++)
            next_cnt.t[i] = w_data[T_TOP-i]; // R6 R13
         next_cnt.sr = w_data[SR_BIT]; // R11
         // Activation only ever sets; a clearing write has no effect
         if (w_data[C_BIT])
            next_sw_act = 1'b1; // R3 R4
      end
      else if (tick)
         next_cnt = CNT_W'(cnt - 1'b1); // R5
      // Stop is honoured when idle, or when gated by the option and the pin
      next_stop_mode = stop_req && (!active || (opt.ext_stop_gate && nmi_q)); // R15
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt       <= wdg_cnt_s'({WATCHDOG_COUNT_CONTROL_REG_RESET[SR_BIT], WATCHDOG_COUNT_CONTROL_REG_RESET[T_TOP:2]}); // R14
         sw_act    <= WATCHDOG_COUNT_CONTROL_REG_RESET[C_BIT]; // R14
         stop_mode <= 1'b0;
      end
      else
      begin
         cnt       <= next_cnt;
         sw_act    <= next_sw_act;
         stop_mode <= next_stop_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset pulse generator

   localparam int PCW = $clog2(PULSE_CYC + 1);

   wdg_fire_e      next_fire_st;
   logic [PCW-1:0] pcnt, next_pcnt;

   // Fires once per expiry; a refresh setting the trigger bit re-arms it
   always_comb
   begin
      next_fire_st = fire_st;
      next_pcnt    = pcnt;
      case (fire_st)
         ST_IDLE:
         begin
            next_pcnt = '0;
            if (active && !cnt.sr)
               next_fire_st = ST_PULSE; // R7 R11
         end
         ST_PULSE:
         begin
            next_pcnt = PCW'(pcnt + 1'b1);
            if (pcnt == PCW'(PULSE_CYC - 1))
               next_fire_st = ST_FIRED; // R7
         end
         ST_FIRED:
         begin
            if (cnt.sr)
               next_fire_st = ST_IDLE;
         end
         default:
            next_fire_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fire_st     <= ST_IDLE;
         pcnt        <= '0;
         wdg_reset_n <= 1'b1;
      end
      else
      begin
         fire_st     <= next_fire_st;
         pcnt        <= next_pcnt;
         wdg_reset_n <= (next_fire_st != ST_PULSE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   logic [7:0] low_len;

   // Helper: length of the current low phase of the reset output
   always_ff @(posedge aclk)
   begin
      if (!aresetn || wdg_reset_n)
         low_len <= '0;
      else
         low_len <= low_len + 8'h01;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   hw_forced_a: assert property (opt.hw_activation |-> active ##1 active) // R1
      else $error("hardware option did not hold the watchdog active");
   sticky_act_a: assert property (sw_act |=> sw_act) // R4
      else $error("activation was cleared without reset");
   step_decr_a: assert property (tick && !wr_watchdog_count_control_reg |=> cnt == $past(cnt) - 7'h01) // R5
      else $error("counter did not step down by one");
   reload_val_a: assert property (wr_watchdog_count_control_reg |=> cnt.sr == $past(w_data[SR_BIT])
                                  && cnt.t[0] == $past(w_data[T_TOP])) // R6
      else $error("refresh did not load the counter");
   pulse_len_a: assert property (!wdg_reset_n ##1 wdg_reset_n |-> $past(low_len) == 8'(PULSE_CYC - 1)) // R7
      else $error("reset pulse has wrong length");
   expiry_fire_a: assert property (fire_st == ST_IDLE && active && !cnt.sr |=> !wdg_reset_n) // R7
      else $error("expiry did not start a reset pulse");
   sw_reset_a: assert property (wr_watchdog_count_control_reg && !w_data[SR_BIT] && active && fire_st == ST_IDLE
                                |=> ##1 !wdg_reset_n) // R11
      else $error("software reset did not pulse the pin");
   idle_quiet_a: assert property (!active && fire_st == ST_IDLE |=> wdg_reset_n) // R3
      else $error("inactive watchdog pulled reset");
   stop_wait_a: assert property (stop_req && active && !(opt.ext_stop_gate && nmi_q)
                                 |=> !stop_mode) // R15
      else $error("stop granted while watchdog guards");
   freeze_a: assert property (stop_mode && !wr_watchdog_count_control_reg |=> $stable(cnt)) // R15
      else $error("counter moved while frozen");
   bad_addr_a: assert property (s_axi_arvalid && s_axi_arready
                                && s_axi_araddr[ADDR_W-1:2] != ADDR_WATCHDOG_COUNT_CONTROL_REG[7:2]
                                && s_axi_araddr[ADDR_W-1:2] != ADDR_STAT[7:2]
                                |=> s_axi_rresp == RESP_SLVERR) // R13
      else $error("unmapped read not refused");
   rst_value_a: assert property (@(posedge aclk) $past(!aresetn) && aresetn
                                 |-> {cnt, sw_act} == WATCHDOG_COUNT_CONTROL_REG_RESET) // R14
      else $error("register reset value wrong");

   expiry_c:   cover property (tick && cnt == wdg_cnt_s'(7'h40) && active);
   sw_reset_c: cover property (wr_watchdog_count_control_reg && !w_data[SR_BIT] && active);
   frozen_c:   cover property (stop_mode && active);
   read_c:     cover property (s_axi_rvalid && s_axi_rready);

endmodule : wdg_top
`default_nettype wire

// File: tb/tb_watchdog_reset_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_reset_timer
   import wdg_pkg::*;
;
   localparam int DP = 8;   // Short decrement period keeps the run brief
   localparam int PC = 3;   // Short reset pulse

   logic              aclk;
   logic              aresetn;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic              awvalid, wvalid, bready, arvalid, rready;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   logic              hw_opt, ext_opt, nmi, stop_req, stop_mode, rst_n;
   int                errors, comparisons, cycles;

   wdg_top #(.DECR_PERIOD(DP), .PULSE_CYC(PC)) dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .activation_source_option(hw_opt),
      .external_stop_gate_option(ext_opt), .nmi_pin(nmi), .stop_req(stop_req),
      .stop_mode(stop_mode), .wdg_reset_n(rst_n));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the ceiling is far above the few hundred cycles used
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus and comparison helpers
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (exp !== got)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      // Each channel is released only at the edge that takes it
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (awvalid && awready) begin awvalid <= 1'b0; aw_ok = 1'b1; end
         if (wvalid && wready) begin wvalid <= 1'b0; w_ok = 1'b1; end
      end
      do @(posedge aclk); while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd

   task do_reset();
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
   endtask : do_reset

   task conclude();
      $display("checks %0d mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_reset_map();
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(ADDR_WATCHDOG_COUNT_CONTROL_REG, d, r);
      chk("watchdog_count_control_reg reset", 32'h000000fe, d);
      axi_rd(8'h10, d, r);
      chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_wr(8'h10, 8'h00, r);
      chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      $display("test reset_map done");
   endtask : t_reset_map

   task t_timer_inactive();
      logic [31:0] d;
      logic [1:0]  r;
      // T0 is bit 7: counter 41h, one decrement gives 40h
      axi_wr(ADDR_WATCHDOG_COUNT_CONTROL_REG, 8'h82, r);
      chk("mapped bresp", {30'h0, RESP_OKAY}, {30'h0, r});
      axi_rd(ADDR_WATCHDOG_COUNT_CONTROL_REG, d, r);
      chk("loaded", 32'h00000082, d);
      repeat (DP + 2) @(posedge aclk);
      axi_rd(ADDR_WATCHDOG_COUNT_CONTROL_REG, d, r);
      chk("one decrement", 32'h00000002, d);
      repeat (2 * DP) @(posedge aclk);
      chk("no reset inactive", 32'h1, {31'h0, rst_n});
      stop_req <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("stop inactive", 32'h1, {31'h0, stop_mode});
      stop_req <= 1'b0;
      repeat (2) @(posedge aclk);
      $display("test timer_inactive done");
   endtask : t_timer_inactive

   task t_expire();
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      axi_wr(ADDR_WATCHDOG_COUNT_CONTROL_REG, 8'h83, r);
      n = 0;
      while (rst_n) begin @(posedge aclk); n++; end
      // Two decrements are needed before the trigger bit clears
      chk("expiry time", 32'h1, {31'h0, (n >= 2 * DP - 4) && (n <= 2 * DP + 4)});
      n = 0;
      while (!rst_n) begin @(posedge aclk); n++; end
      chk("pulse width", PC, n);
      axi_wr(ADDR_WATCHDOG_COUNT_CONTROL_REG, 8'hfe, r);
      axi_rd(ADDR_WATCHDOG_COUNT_CONTROL_REG, d, r);
      chk("clear ignored", 32'h000000ff, d);
      $display("test expire done");
   endtask : t_expire

   task t_stop_active();
      logic [31:0] d1, d2;
      logic [1:0]  r;
      stop_req <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("stop as wait", 32'h0, {31'h0, stop_mode});
      ext_opt <= 1'b1;
      nmi     <= 1'b1;
      repeat (5) @(posedge aclk);
      chk("gated stop", 32'h1, {31'h0, stop_mode});
      // Status: ext option, active and stop set; no pulse pending after refresh
      axi_rd(ADDR_STAT, d1, r);
      chk("status", 32'h0000000e, d1);
      axi_rd(ADDR_WATCHDOG_COUNT_CONTROL_REG, d1, r);
      repeat (3 * DP) @(posedge aclk);
      axi_rd(ADDR_WATCHDOG_COUNT_CONTROL_REG, d2, r);
      chk("frozen count", d1, d2);
      stop_req <= 1'b0;
      ext_opt  <= 1'b0;
      nmi      <= 1'b0;
      repeat (4) @(posedge aclk);
      $display("test stop_active done");
   endtask : t_stop_active

   task t_soft_reset();
      logic [1:0] r;
      int         n;
      axi_wr(ADDR_WATCHDOG_COUNT_CONTROL_REG, 8'hfd, r);
      n = 0;
      while (rst_n && n < 10) begin @(posedge aclk); n++; end
      chk("soft reset", 32'h1, {31'h0, n <= 4});
      repeat (PC + 2) @(posedge aclk);
      $display("test soft_reset done");
   endtask : t_soft_reset

   task t_hw_option();
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      hw_opt <= 1'b1;
      do_reset();
      axi_rd(ADDR_WATCHDOG_COUNT_CONTROL_REG, d, r);
      chk("hw active", 32'h000000ff, d);
      axi_wr(ADDR_WATCHDOG_COUNT_CONTROL_REG, 8'h02, r);
      axi_rd(ADDR_WATCHDOG_COUNT_CONTROL_REG, d, r);
      chk("hw c forced", 32'h00000003, d);
      n = 0;
      while (rst_n && n < 4 * DP) begin @(posedge aclk); n++; end
      chk("hw expiry", 32'h0, {31'h0, rst_n});
      $display("test hw_option done");
   endtask : t_hw_option

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      errors = 0;
      comparisons = 0;
      cycles = 0;
      aresetn <= 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
      awaddr <= 8'h00;
      araddr <= 8'h00;
      wdata  <= 32'h00000000;
      wstrb  <= 4'h1;
      {hw_opt, ext_opt, nmi, stop_req} <= 4'h0;
      do_reset();
      t_reset_map();
      t_timer_inactive();
      t_expire();
      t_stop_active();
      t_soft_reset();
      t_hw_option();
      conclude();
   end
endmodule : tb_watchdog_reset_timer
`default_nettype wire
